// ===== design/ssd_params.svh
// constants of the five-phase step driver control block
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

`define SSD_CLK_HZ          20000000
`define SSD_STOP_DELAY_MS   100
`define SSD_STOP_DELAY_CYC  (`SSD_STOP_DELAY_MS * (`SSD_CLK_HZ / 1000))
`define SSD_TEST_PPS        3
// a rate: period rounds down to whole cycles
`define SSD_TEST_PERIOD_CYC (`SSD_CLK_HZ / `SSD_TEST_PPS)
`define SSD_CNT_W           23

`define SSD_NUM_PHASES      5
`define SSD_HALF_STATES     5'h14
`define SSD_HALF_TURN       6'h0A
`define SSD_PHASE_SPAN      4

`define SSD_PCT_RUN         7'h64
`define SSD_PCT_MIN         7'h0D
`define SSD_PCT_RST         7'h32

`define SSD_IN_PULSE        0
`define SSD_IN_DIR          1
`define SSD_IN_AWO          2
`define SSD_IN_HOT          3

`define SSD_OFS_CTRL        8'h00
`define SSD_OFS_STATUS      8'h04
`define SSD_OFS_IRQ_STAT    8'h08
`define SSD_OFS_IRQ_MASK    8'h0C

`define SSD_CTRL_HALF       0
`define SSD_CTRL_DUAL       1
`define SSD_CTRL_TEST       2
`define SSD_CTRL_CUTBACK    3
`define SSD_CTRL_CUTOFF     4
`define SSD_CTRL_PCT_LO     5
`define SSD_CTRL_PCT_HI     11

`define SSD_ST_IDX_HI       4
`define SSD_ST_STILL        8
`define SSD_ST_HOT          9
`define SSD_ST_CUT          10
`define SSD_ST_AWO          11

`define SSD_EV_STEP         0
`define SSD_EV_HOT          1
`define SSD_EV_COOL         2
`define SSD_EV_STILL        3
`define SSD_EV_W            4

`endif

// ===== design/ssd_pkg.sv
// types of the five-phase step driver control block
`include "ssd_params.svh"
package ssd_pkg;

    typedef struct packed {
        logic [6:0] stop_pct;
        logic       cutoff_en;
        logic       cutback_en;
        logic       self_test;
        logic       dual_pulse;
        logic       half_step;
    } ssd_ctrl_t;

    typedef struct packed {
        logic [3:0]             sync1;
        logic [3:0]             sync2;
        logic [3:0]             prev;
        ssd_ctrl_t              ctrl;
        logic [`SSD_EV_W-1:0]   irq_stat;
        logic [`SSD_EV_W-1:0]   irq_mask;
        logic [4:0]             idx;
        logic [`SSD_CNT_W-1:0]  idle_cnt;
        logic                   standstill;
        logic [`SSD_CNT_W-1:0]  test_cnt;
        logic                   cutoff;
        logic [4:0]             ph_en;
        logic [4:0]             ph_pos;
        logic [6:0]             cur_pct;
        logic                   overheat;
        logic                   irq;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } ssd_state_t;

endpackage

// ===== design/ssd_step_ctrl.sv
// five-phase step driver control: excitation sequencer, cutback, thermal cutoff, apb regs
//
// Contract
// - after 100 ms idle, cut current to fraction
// - windings stay energised at standstill
// - overtemp with cutoff enabled removes winding current
// - overheat output follows overtemp regardless of enable
// - cutoff self-clears when overtemp goes away
// - full step by two, half step by one; the code moves a full step from an odd index by one
// - single-pulse: one step per step pulse
// - dual-pulse: each input steps one sense
// - self test steps internally at 3 pps
// - single-pulse: sense high is ccw, low cw
// - dual-pulse: step input cw, sense input ccw
// - excitation starts at step zero after reset
// - windings-off input removes all winding current
`include "ssd_params.svh"
module ssd_step_ctrl
    import ssd_pkg::*;
#(
    parameter int STOP_DELAY_CYC  = `SSD_STOP_DELAY_CYC,
    parameter int TEST_PERIOD_CYC = `SSD_TEST_PERIOD_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pulse_in,
    input  wire logic        rotation_sense_input,
    input  wire logic        windings_off_in,
    input  wire logic        overtemp_in,
    output logic      [4:0]  phase_en,
    output logic      [4:0]  phase_pos,
    output logic      [6:0]  current_pct,
    output logic             overheat_out,
    output logic             irq
);

    localparam ssd_ctrl_t CTRL_RST = '{
        stop_pct:   `SSD_PCT_RST,
        cutoff_en:  1'b1,
        cutback_en: 1'b1,
        self_test:  1'b0,
        dual_pulse: 1'b0,
        half_step:  1'b0
    };
    // reset image: only the switch settings differ from zero
    localparam ssd_state_t ST_RST = '{ctrl: CTRL_RST, default: '0};
    // counters compare against the last count, so a period of n spans n clocks
    localparam logic [`SSD_CNT_W-1:0] STOP_LAST = `SSD_CNT_W'(STOP_DELAY_CYC - 1);
    localparam logic [`SSD_CNT_W-1:0] TEST_LAST = `SSD_CNT_W'(TEST_PERIOD_CYC - 1);

    ssd_state_t r;
    ssd_state_t s;

    // winding pattern of the current index; registered outputs trail idx by one cycle
    // both are pure functions of idx, so standing outputs follow idx alone
    logic [4:0] pat_on;
    logic [4:0] pat_pos;

    genvar p;
    generate
        for (p = 0; p < `SSD_NUM_PHASES; p++) begin : g_phase
            // d is the distance of this phase from the index, in half-steps
            logic [5:0] d_raw;
            logic [5:0] d;
            assign d_raw = {1'b0, r.idx} + {1'b0, `SSD_HALF_STATES}
                           - 6'(`SSD_PHASE_SPAN * p);
            assign d     = (d_raw >= {1'b0, `SSD_HALF_STATES}) ?
                           d_raw - {1'b0, `SSD_HALF_STATES} : d_raw;
            // even index leaves one phase off, odd index has all five on
            assign pat_on[p]  = (d != 6'h00) && (d != `SSD_HALF_TURN);
            assign pat_pos[p] = (d > 6'h00) && (d < `SSD_HALF_TURN);
        end
    endgenerate

    // index scheme: idx counts half-steps 0..19 clockwise; even codes are the
    // four-on states, odd codes all five on, so a full step from an even code moves two codes
    // everything below is next-state only; the single always_ff commits it,
    // which keeps every output a plain flop
    always_comb begin
        logic [3:0]          rise;
        logic                hot;
        logic                awo;
        logic                tick;
        logic                step_req;
        logic                ccw;
        logic [4:0]          inc;
        logic                wr;
        logic [`SSD_EV_W-1:0] ev;
        logic [`SSD_EV_W-1:0] clr;
        logic [6:0]          stop_c;
        s        = r;
        tick     = 1'b0;
        step_req = 1'b0;
        ccw      = 1'b0;
        ev       = '0;
        clr      = '0;
        rise     = '0;
        hot      = 1'b0;
        awo      = 1'b0;
        inc      = 5'h01;
        wr       = 1'b0;
        stop_c   = `SSD_PCT_RUN;

        // two flops on every pin before use
        // prev only ever sees the second stage, so a metastable first stage
        // never reaches the edge detector
        s.sync1[`SSD_IN_PULSE] = pulse_in;
        s.sync1[`SSD_IN_DIR]   = rotation_sense_input;
        s.sync1[`SSD_IN_AWO]   = windings_off_in;
        s.sync1[`SSD_IN_HOT]   = overtemp_in;
        s.sync2 = r.sync1;
        s.prev  = r.sync2;
        rise    = r.sync2 & ~r.prev;
        hot     = r.sync2[`SSD_IN_HOT];
        awo     = r.sync2[`SSD_IN_AWO];

        // cutoff follows the synced level directly: it clears itself when the
        // pin drops, and a late enable write takes effect within a cycle
        s.overheat = hot;
        s.cutoff   = hot & r.ctrl.cutoff_en;
        ev[`SSD_EV_HOT]  = hot & ~r.overheat;
        ev[`SSD_EV_COOL] = r.cutoff & ~s.cutoff;

        // the generator only runs while selected; leaving test mode restarts
        // its period from zero
        if (r.ctrl.self_test) begin
            if (r.test_cnt >= TEST_LAST) begin
                s.test_cnt = '0;
                tick       = 1'b1;
            end else begin
                s.test_cnt = r.test_cnt + 1'b1;
            end
        end else begin
            s.test_cnt = '0;
        end

        if (r.ctrl.self_test) begin
            // external pulses ignored, internal steps go clockwise
            step_req = tick;
            ccw      = 1'b0;
        end else if (r.ctrl.dual_pulse) begin
            // edges on both inputs in the same cycle cancel: nothing sensible to do with both
            step_req = rise[`SSD_IN_PULSE] ^ rise[`SSD_IN_DIR];
            ccw      = rise[`SSD_IN_DIR];
        end else begin
            // the sense level is taken in the same cycle as the edge, both
            // through equal synchronisers, so the two stay aligned
            step_req = rise[`SSD_IN_PULSE];
            ccw      = r.sync2[`SSD_IN_DIR];
        end
        // steps arriving while cut off are dropped, not queued
        if (r.cutoff) begin
            step_req = 1'b0;
        end

        // an odd index in full-step mode first lands on an even state
        if (r.ctrl.half_step | r.idx[0]) begin
            inc = 5'h01;
        end else begin
            inc = 5'h02;
        end
        if (step_req) begin
            ev[`SSD_EV_STEP] = 1'b1;
            if (ccw) begin
                if (r.idx < inc) begin
                    s.idx = r.idx + `SSD_HALF_STATES - inc;
                end else begin
                    s.idx = r.idx - inc;
                end
            end else begin
                if (r.idx + inc >= `SSD_HALF_STATES) begin
                    s.idx = r.idx + inc - `SSD_HALF_STATES;
                end else begin
                    s.idx = r.idx + inc;
                end
            end
        end

        // an accepted step restarts the stop delay from zero; the counter
        // saturates at its last count, so a long stop never leaves standstill

        if (step_req) begin
            s.idle_cnt   = '0;
            s.standstill = 1'b0;
        end else if (r.idle_cnt >= STOP_LAST) begin
            s.standstill = 1'b1;
            ev[`SSD_EV_STILL] = ~r.standstill;
        end else begin
            s.idle_cnt = r.idle_cnt + 1'b1;
        end

        // out-of-range settings are clamped rather than refused: a zero would
        // release the holding torque at standstill
        stop_c = r.ctrl.stop_pct;
        if (stop_c < `SSD_PCT_MIN) begin
            stop_c = `SSD_PCT_MIN;
        end else if (stop_c > `SSD_PCT_RUN) begin
            stop_c = `SSD_PCT_RUN;
        end

        // windings-off and cutoff both zero the command and every phase enable;
        // idx keeps counting under windings-off
        if (r.cutoff | awo) begin
            s.ph_en   = '0;
            s.cur_pct = '0;
        end else begin
            // held energised at standstill, only the level drops
            s.ph_en   = pat_on;
            if (r.standstill & r.ctrl.cutback_en) begin
                s.cur_pct = stop_c;
            end else begin
                s.cur_pct = `SSD_PCT_RUN;
            end
        end
        // polarity keeps tracking idx even while off, so drive resumes on the
        // right pattern without a re-sync step
        s.ph_pos = pat_pos;

        // apb: answer prepared in setup, so access completes at its first edge
        // pready is only ever set for one access cycle, so wr fires once per
        // transfer
        wr = psel & penable & pwrite & r.pready;
        if (wr) begin
            unique case (paddr)
                `SSD_OFS_CTRL: begin
                    s.ctrl.half_step  = pwdata[`SSD_CTRL_HALF];
                    s.ctrl.dual_pulse = pwdata[`SSD_CTRL_DUAL];
                    s.ctrl.self_test  = pwdata[`SSD_CTRL_TEST];
                    s.ctrl.cutback_en = pwdata[`SSD_CTRL_CUTBACK];
                    s.ctrl.cutoff_en  = pwdata[`SSD_CTRL_CUTOFF];
                    s.ctrl.stop_pct   = pwdata[`SSD_CTRL_PCT_HI:`SSD_CTRL_PCT_LO];
                end
                `SSD_OFS_IRQ_STAT: clr        = pwdata[`SSD_EV_W-1:0];
                `SSD_OFS_IRQ_MASK: s.irq_mask = pwdata[`SSD_EV_W-1:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        s.irq_stat = (r.irq_stat & ~clr) | ev;
        // built from the next status so irq rises with the event bit, not a
        // cycle after it
        s.irq      = |(s.irq_stat & s.irq_mask);

        // read data is taken from the state at the setup edge; a step landing
        // in the access cycle shows up on the next read
        if (psel & ~penable) begin
            s.pready  = 1'b1;
            s.pslverr = 1'b0;
            s.prdata  = '0;
            unique case (paddr)
                `SSD_OFS_CTRL:     s.prdata[11:0] = r.ctrl;
                `SSD_OFS_STATUS: begin
                    s.prdata[`SSD_ST_IDX_HI:0] = r.idx;
                    s.prdata[`SSD_ST_STILL]    = r.standstill;
                    s.prdata[`SSD_ST_HOT]      = r.overheat;
                    s.prdata[`SSD_ST_CUT]      = r.cutoff;
                    s.prdata[`SSD_ST_AWO]      = awo;
                end
                `SSD_OFS_IRQ_STAT: s.prdata[`SSD_EV_W-1:0] = r.irq_stat;
                `SSD_OFS_IRQ_MASK: s.prdata[`SSD_EV_W-1:0] = r.irq_mask;
                default:           s.pslverr = 1'b1;
            endcase
        end else begin
            // outside setup the answer lines drop; prdata keeps its last value
            s.pready  = 1'b0;
            s.pslverr = 1'b0;
        end
    end

    // async clear brings idx to zero and every drive output low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= ST_RST;
        end else begin
            r <= s;
        end
    end

    // ports are straight flop outputs, no logic after the register
    assign prdata       = r.prdata;
    assign pready       = r.pready;
    assign pslverr      = r.pslverr;
    assign phase_en     = r.ph_en;
    assign phase_pos    = r.ph_pos;
    assign current_pct  = r.cur_pct;
    assign overheat_out = r.overheat;
    assign irq          = r.irq;

endmodule // ssd_step_ctrl

// ===== tb/ssd_step_ctrl_asserts.sv
// port checker for the step driver control block
module ssd_chk_asserts (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       overtemp_in,
    input wire logic       windings_off_in,
    input wire logic       overheat_out,
    input wire logic [4:0] phase_en,
    input wire logic [6:0] current_pct
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !windings_off_in && !overheat_out;
    endsequence
    chk_one_wait: assert property (s_setup |=> pready ##1 !pready)
        else $error("access not answered in one cycle");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_hot_flag:
        assert property (overtemp_in[*5] |-> overheat_out) else $error("overheat flag missing");
    chk_cool_flag:
        assert property ((!overtemp_in)[*5] |-> !overheat_out) else $error("overheat flag stuck");
    chk_cool_resume:
        assert property ($fell(overheat_out) && !windings_off_in |-> ##[0:2] phase_en != 5'h00)
        else $error("drive not resumed after cooling");
    chk_awo_off:
        assert property (windings_off_in[*5] |-> phase_en == 5'h00 && current_pct == 7'h00)
        else $error("windings still driven");
    chk_hold_on:
        assert property (s_quiet[*6] |-> phase_en != 5'h00) else $error("windings released");
    chk_pct_span:
        assert property (current_pct != 7'h00 |-> current_pct >= 7'h0D && current_pct <= 7'h64)
        else $error("current command out of span");
endmodule // ssd_chk_asserts
bind ssd_step_ctrl ssd_chk_asserts u_chk (.*);

// ===== tb/ssd_pulse_ctl.sv
// external step pulse controller model
module ssd_pulse_ctl (
    input wire logic pclk,
    output logic     step_o,
    output logic     sense_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        step_o = 1'b0;
        sense_o = 1'b0;
    end
    // 3 clocks high and low so the two-stage synchroniser sees every edge
    task automatic pulses(input logic dual, input logic ccw, input int n);
        sense_o <= dual ? 1'b0 : ccw;
        repeat (4) @(posedge pclk);
        repeat (n) begin
            if (dual && ccw) sense_o <= 1'b1;
            else step_o <= 1'b1;
            repeat (3) @(posedge pclk);
            step_o <= 1'b0;
            if (dual) sense_o <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule // ssd_pulse_ctl

// ===== tb/ssd_step_ctrl_tb.sv
// self-checking bench for the step driver control block
module ssd_step_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        pulse_in, rotation_sense_input, windings_off_in, overtemp_in;
    logic        overheat_out, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  phase_en, phase_pos, a;
    logic [6:0]  current_pct;
    int          error_cnt, n_compared;
    ssd_step_ctrl #(.STOP_DELAY_CYC(20), .TEST_PERIOD_CYC(10)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
        .rotation_sense_input(rotation_sense_input), .windings_off_in(windings_off_in),
        .overtemp_in(overtemp_in), .phase_en(phase_en), .phase_pos(phase_pos),
        .current_pct(current_pct), .overheat_out(overheat_out), .irq(irq));
    ssd_pulse_ctl PC (.pclk(pclk), .step_o(pulse_in), .sense_o(rotation_sense_input));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // releases for one idle cycle so no signal is assigned twice in a time step
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] m, e, input string nm);
        apb(1'b0, ad, 32'h0);
        chk(nm, q & m, e);
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, windings_off_in, overtemp_in} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        cyc(2);
        presetn <= 1'b1;
        cyc(2);
        chk("phase_en", phase_en, 5'h1E);
        chk("phase_pos", phase_pos, 5'h18);
        rd(8'h00, 32'hFFFFFFFF, 32'h658, "ctrl");
        rd(8'h0C, 32'hFFFFFFFF, 32'h0, "mask");
        rd(8'h04, 32'h1F, 32'h0, "idx");
        PC.pulses(1'b0, 1'b0, 3);
        rd(8'h04, 32'h1F, 32'h6, "idx");
        PC.pulses(1'b0, 1'b1, 4);
        rd(8'h04, 32'h1F, 32'h12, "idx");
        apb(1'b1, 8'h00, 32'h659);
        PC.pulses(1'b0, 1'b0, 1);
        chk("phase_en", phase_en, 5'h1F);
        rd(8'h04, 32'h1F, 32'h13, "idx");
        PC.pulses(1'b0, 1'b0, 1);
        rd(8'h04, 32'h1F, 32'h0, "idx");
        apb(1'b1, 8'h00, 32'h65A);
        PC.pulses(1'b1, 1'b0, 2);
        PC.pulses(1'b1, 1'b1, 1);
        rd(8'h04, 32'h1F, 32'h2, "idx");
        cyc(30);
        chk("cur", current_pct, 7'h32);
        rd(8'h04, 32'h100, 32'h100, "still");
        apb(1'b1, 8'h00, 32'hBA);
        cyc(3);
        chk("cur", current_pct, 7'h0D);
        apb(1'b1, 8'h00, 32'hB2);
        cyc(3);
        chk("cur", current_pct, 7'h64);
        chk("irq", irq, 1'b0);
        apb(1'b1, 8'h0C, 32'h8);
        cyc(2);
        chk("irq", irq, 1'b1);
        apb(1'b1, 8'h08, 32'hF);
        cyc(2);
        chk("irq", irq, 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", err, 1'b1);
        overtemp_in <= 1'b1;
        cyc(5);
        chk("hot", overheat_out, 1'b1);
        chk("phase_en", phase_en, 5'h00);
        chk("cur", current_pct, 7'h00);
        PC.pulses(1'b1, 1'b0, 1);
        rd(8'h04, 32'h1F, 32'h2, "idx");
        overtemp_in <= 1'b0;
        cyc(5);
        chk("drive", phase_en != 5'h00, 1'b1);
        PC.pulses(1'b1, 1'b0, 1);
        rd(8'h04, 32'h1F, 32'h4, "idx");
        apb(1'b1, 8'h00, 32'hA2);
        overtemp_in <= 1'b1;
        cyc(5);
        chk("hot", overheat_out, 1'b1);
        chk("drive", phase_en != 5'h00, 1'b1);
        overtemp_in <= 1'b0;
        windings_off_in <= 1'b1;
        cyc(5);
        chk("phase_en", phase_en, 5'h00);
        chk("cur", current_pct, 7'h00);
        windings_off_in <= 1'b0;
        apb(1'b1, 8'h00, 32'hA6);
        rd(8'h04, 32'h1F, 32'h4, "idx");
        a = q[4:0];
        PC.pulses(1'b1, 1'b1, 2);
        cyc(31);
        apb(1'b0, 8'h04, 32'h0);
        chk("rate", (32'(q[4:0]) + 32'd20 - 32'(a)) % 32'd20, 32'd10);
        results();
    end
endmodule // ssd_step_ctrl_tb
